// ==== src/hgc_global_regs.sv ====
// Global control register bank of the four-input camera hub.
// Assumes the serial control slave hands over decoded single-byte reads and writes,
// and that the fuse loader answers each start pulse with one done pulse.
//
// Notes on behaviour
// RULE1: Address field read always returns the bus address currently answered to.
// RULE2: With override clear, address field is read-only and shows strapped address.
// RULE3: With override set, written address field becomes the answered bus address.
// RULE4: Reload bit restarts fuse configuration loading and clears itself.
// RULE5: Init-done status bit sets once fuse configuration loading has finished.
// RULE6: Full reset bit resets all logic including registers, then self-clears.
// RULE7: Logic-only reset bit resets logic, keeps registers, then self-clears.
// RULE8: Mode bit zero without assigned lock puts the output port in high impedance.
// RULE9: Mode bit one keeps output under per-port control, LP-11 without lock.
// RULE10: Sleep select one with output enable zero forces outputs to high impedance.
// RULE11: Sleep select zero with lock low drives outputs in HS-0.
// RULE12: Parity checker enable bit switches receive parity checking on or off.
// RULE13: Per-port parity flag sets once error count reaches the 16-bit threshold.
// RULE14: Sleep select and output enable both one leave outputs unforced.
`timescale 1ns/1ps
module hgc_global_regs
  import hgc_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire hgc_reg_req_s         reg_req_in,
  input  wire logic [6:0]           strap_address_in,
  input  wire logic [NUM_PORTS-1:0] rx_lock_in,
  input  wire logic [NUM_PORTS-1:0] port_assign_in,
  input  wire logic                 port_tx_enable_in,
  input  wire logic                 fuse_load_done_in,
  input  wire logic [NUM_PORTS-1:0] parity_error_in,
  output logic [7:0]                reg_rdata_out,
  output logic [6:0]                bus_address_out,
  output logic                      fuse_load_start_out,
  output logic                      logic_reset_out,
  output logic                      init_done_out,
  output hgc_cfg_s                  cfg_out,
  output hgc_tx_state_e             tx_state_out,
  output logic [NUM_PORTS-1:0]      parity_flag_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic                 strap_taken_reg;
  logic [6:0]           strap_addr_reg;
  logic [6:0]           addr_field_reg;
  logic                 override_reg;
  logic                 reload_reg;
  logic                 full_rst_reg;
  logic                 logic_rst_reg;
  logic                 rsvd_rw_reg;
  logic [7:0]           cfg_reg;
  logic [7:0]           thr_hi_reg;
  logic [7:0]           thr_lo_reg;
  logic                 init_done_reg;
  logic                 start_reg;
  hgc_load_state_e      load_reg;
  hgc_load_state_e      load_next;
  logic [7:0]           rdata_reg;
  hgc_tx_state_e        tx_reg;
  hgc_tx_state_e        tx_next;
  logic [15:0]          cnt_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] flag_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic        wr_addr    = reg_req_in.wr && (reg_req_in.addr == HGC_OFS_ADDR);
  wire logic        wr_reset   = reg_req_in.wr && (reg_req_in.addr == HGC_OFS_RESET);
  wire logic        wr_cfg     = reg_req_in.wr && (reg_req_in.addr == HGC_OFS_CFG);
  wire logic        wr_thr_hi  = reg_req_in.wr && (reg_req_in.addr == HGC_OFS_THR_HI);
  wire logic        wr_thr_lo  = reg_req_in.wr && (reg_req_in.addr == HGC_OFS_THR_LO);
  wire logic        regs_clear = full_rst_reg;
  wire logic        logic_clear = full_rst_reg || logic_rst_reg;
  wire logic [15:0] threshold  = {thr_hi_reg, thr_lo_reg};
  wire logic        any_lock   = |(rx_lock_in & port_assign_in);
  wire logic        reload_go  = (wr_reset && reg_req_in.wdata[HGC_BIT_RELOAD]) || full_rst_reg;
  wire logic [6:0]  cur_addr   = override_reg ? addr_field_reg : strap_addr_reg; // RULE1 RULE2 RULE3

  assign cfg_out.out_mode  = cfg_reg[HGC_BIT_OUT_MODE];
  assign cfg_out.out_en    = cfg_reg[HGC_BIT_OUT_EN];
  assign cfg_out.sleep_sel = cfg_reg[HGC_BIT_SLEEP_SEL];
  assign cfg_out.parity_en = cfg_reg[HGC_BIT_PAR_EN]; // RULE12

  wire logic [7:0] read_mux =
    (reg_req_in.addr == HGC_OFS_ADDR)   ? {cur_addr, override_reg} :
    (reg_req_in.addr == HGC_OFS_RESET)  ? {2'b00, rsvd_rw_reg, 2'b00, reload_reg, full_rst_reg, logic_rst_reg} :
    (reg_req_in.addr == HGC_OFS_CFG)    ? (cfg_reg & HGC_CFG_WMASK) :
    (reg_req_in.addr == HGC_OFS_STATUS) ? ({7'h00, init_done_reg} << HGC_BIT_INIT_DONE) :
    (reg_req_in.addr == HGC_OFS_THR_HI) ? thr_hi_reg :
    (reg_req_in.addr == HGC_OFS_THR_LO) ? thr_lo_reg : 8'h00;

  // ----------------------------------------
  // Strap capture and address register
  // ----------------------------------------
  // The strap is caught on the first clock after release and again on a full reset, never by the async reset itself.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      strap_taken_reg <= 1'b0;
      strap_addr_reg  <= HGC_ADDR_RESET;
    end
    else if (!strap_taken_reg || regs_clear)
    begin
      strap_taken_reg <= 1'b1;
      strap_addr_reg  <= strap_address_in; // RULE2
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      override_reg   <= 1'b0;
      addr_field_reg <= HGC_ADDR_RESET;
    end
    else if (regs_clear)
    begin
      override_reg   <= 1'b0; // RULE6
      addr_field_reg <= HGC_ADDR_RESET;
    end
    else if (wr_addr)
    begin
      override_reg <= reg_req_in.wdata[HGC_BIT_OVERRIDE];
      if (reg_req_in.wdata[HGC_BIT_OVERRIDE])
        addr_field_reg <= reg_req_in.wdata[7:1]; // RULE3
    end
  end

  // ----------------------------------------
  // Reset control and configuration
  // ----------------------------------------
  // Self-clearing bits live exactly one cycle, so a read in that cycle sees them set.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reload_reg    <= 1'b0;
      full_rst_reg  <= 1'b0;
      logic_rst_reg <= 1'b0;
      rsvd_rw_reg   <= 1'b0;
      cfg_reg       <= HGC_CFG_RESET;
      thr_hi_reg    <= HGC_THR_HI_RESET;
      thr_lo_reg    <= HGC_THR_LO_RESET;
    end
    else
    begin
      reload_reg    <= wr_reset && reg_req_in.wdata[HGC_BIT_RELOAD] && !regs_clear; // RULE4
      full_rst_reg  <= wr_reset && reg_req_in.wdata[HGC_BIT_FULL_RST] && !regs_clear; // RULE6
      logic_rst_reg <= wr_reset && reg_req_in.wdata[HGC_BIT_LOGIC_RST] && !regs_clear; // RULE7
      if (regs_clear)
      begin
        rsvd_rw_reg <= 1'b0; // RULE6
        cfg_reg     <= HGC_CFG_RESET;
        thr_hi_reg  <= HGC_THR_HI_RESET;
        thr_lo_reg  <= HGC_THR_LO_RESET;
      end
      else
      begin
        if (wr_reset)
          rsvd_rw_reg <= reg_req_in.wdata[HGC_BIT_RSVD_RW];
        if (wr_cfg)
          cfg_reg <= reg_req_in.wdata & HGC_CFG_WMASK;
        if (wr_thr_hi)
          thr_hi_reg <= reg_req_in.wdata;
        if (wr_thr_lo)
          thr_lo_reg <= reg_req_in.wdata;
      end
    end
  end

  // ----------------------------------------
  // Fuse configuration loader handshake
  // ----------------------------------------
  always_comb
  begin
    load_next = load_reg;
    case (load_reg)
      HGC_LOAD_IDLE: if (reload_go) load_next = HGC_LOAD_BUSY; // RULE4
      HGC_LOAD_BUSY: if (fuse_load_done_in && !reload_go) load_next = HGC_LOAD_IDLE; // RULE5
      default:       load_next = HGC_LOAD_IDLE;
    endcase
  end

  // A load starts by itself after power-up reset, so init-done is low until it ends.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      load_reg      <= HGC_LOAD_BUSY;
      start_reg     <= 1'b1;
      init_done_reg <= 1'b0;
    end
    else
    begin
      load_reg      <= load_next;
      start_reg     <= reload_go;
      init_done_reg <= (load_next == HGC_LOAD_IDLE); // RULE5
    end
  end

  // ----------------------------------------
  // Output port state
  // ----------------------------------------
  always_comb
  begin
    if (cfg_out.sleep_sel && !cfg_out.out_en)
      tx_next = HGC_TX_HIZ; // RULE10
    else if (!any_lock && !cfg_out.out_mode)
      tx_next = HGC_TX_HIZ; // RULE8
    else if (!any_lock && !cfg_out.sleep_sel)
      tx_next = HGC_TX_HS0; // RULE11
    else if (!any_lock || !port_tx_enable_in)
      tx_next = HGC_TX_LP11; // RULE9
    else
      tx_next = HGC_TX_NORMAL; // RULE14
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_reg    <= HGC_TX_HIZ;
      rdata_reg <= 8'h00;
    end
    else
    begin
      tx_reg <= logic_clear ? HGC_TX_HIZ : tx_next;
      if (reg_req_in.rd)
        rdata_reg <= read_mux; // RULE1
    end
  end

  // ----------------------------------------
  // Parity error counting per port
  // ----------------------------------------
  // Counters saturate rather than wrap so a flag can never be missed by overflow.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_parity
    wire logic        hit      = parity_error_in[p] && cfg_out.parity_en; // RULE12
    wire logic [15:0] cnt_next = (hit && cnt_reg[p] != HGC_CNT_MAX) ? cnt_reg[p] + 16'h0001 : cnt_reg[p];
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
      begin
        cnt_reg[p]  <= 16'h0000;
        flag_reg[p] <= 1'b0;
      end
      else if (logic_clear)
      begin
        cnt_reg[p]  <= 16'h0000; // RULE7
        flag_reg[p] <= 1'b0;
      end
      else
      begin
        cnt_reg[p]  <= cnt_next;
        flag_reg[p] <= flag_reg[p] || (cnt_next >= threshold); // RULE13
      end
    end
  end

  assign reg_rdata_out       = rdata_reg;
  assign bus_address_out     = cur_addr;
  assign fuse_load_start_out = start_reg;
  assign logic_reset_out     = logic_clear;
  assign init_done_out       = init_done_reg;
  assign tx_state_out        = tx_reg;
  assign parity_flag_out     = flag_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_reload_write;
    wr_reset && reg_req_in.wdata[HGC_BIT_RELOAD] && !full_rst_reg;
  endsequence

  sequence s_reload_seen;
    reload_reg && fuse_load_start_out ##1 !reload_reg;
  endsequence

  a_addr_follows: assert property (!override_reg |-> bus_address_out == strap_addr_reg) // RULE2
    else $error("address does not follow strap");
  a_addr_override: assert property (wr_addr && reg_req_in.wdata[0] && !full_rst_reg
      |=> bus_address_out == $past(reg_req_in.wdata[7:1])) // RULE3
    else $error("override address not taken");
  a_addr_readback: assert property (reg_req_in.rd && reg_req_in.addr == HGC_OFS_ADDR
      |=> reg_rdata_out[7:1] == $past(bus_address_out)) // RULE1
    else $error("address readback wrong");
  a_reload_clear: assert property (s_reload_write |=> s_reload_seen) // RULE4
    else $error("reload bit not self-clearing");
  a_init_done: assert property (load_reg == HGC_LOAD_BUSY && fuse_load_done_in && !reload_go
      |=> init_done_out) // RULE5
    else $error("init done not set");
  a_full_reset: assert property (wr_reset && reg_req_in.wdata[1] && !full_rst_reg
      |=> full_rst_reg ##1 !full_rst_reg && cfg_reg == HGC_CFG_RESET) // RULE6
    else $error("full reset did not restore registers");
  a_logic_reset: assert property (logic_rst_reg && !full_rst_reg |=> $stable(cfg_reg) && flag_reg == '0) // RULE7
    else $error("logic reset touched registers");
  a_tx_hiz: assert property (!any_lock && !cfg_out.out_mode && !logic_clear |=> tx_state_out == HGC_TX_HIZ) // RULE8
    else $error("output not high impedance");
  a_tx_sleep: assert property (cfg_out.sleep_sel && !cfg_out.out_en && !logic_clear
      |=> tx_state_out == HGC_TX_HIZ) // RULE10
    else $error("sleep high impedance missing");
  a_tx_hs0: assert property (!any_lock && cfg_out.out_mode && !cfg_out.sleep_sel && !logic_clear
      |=> tx_state_out == HGC_TX_HS0) // RULE11
    else $error("HS-0 state missing");
  a_tx_lp11: assert property (!any_lock && cfg_out.out_mode && cfg_out.sleep_sel && cfg_out.out_en
      && !logic_clear |=> tx_state_out == HGC_TX_LP11) // RULE9
    else $error("LP-11 state missing");
  a_tx_normal: assert property (any_lock && port_tx_enable_in && cfg_out.sleep_sel && cfg_out.out_en
      && !logic_clear |=> tx_state_out == HGC_TX_NORMAL) // RULE14
    else $error("output forced while enabled");
  a_parity_off: assert property (!cfg_out.parity_en && !logic_clear |=> $stable(cnt_reg[0])) // RULE12
    else $error("parity counted while disabled");
  a_parity_flag: assert property (!logic_clear && cnt_reg[0] >= threshold |=> parity_flag_out[0]) // RULE13
    else $error("parity flag not set");

endmodule // hgc_global_regs

// ==== src/hgc_pkg.sv ====
// Constants, field positions and carrier types of the hub global control bank.
// Assumes byte-wide register access decoded by the device's serial control slave.
package hgc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] HGC_OFS_ADDR   = 8'h00;
  localparam logic [7:0] HGC_OFS_RESET  = 8'h01;
  localparam logic [7:0] HGC_OFS_CFG    = 8'h02;
  localparam logic [7:0] HGC_OFS_STATUS = 8'h04;
  localparam logic [7:0] HGC_OFS_THR_HI = 8'h05;
  localparam logic [7:0] HGC_OFS_THR_LO = 8'h06;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int HGC_BIT_OVERRIDE  = 0;
  localparam int HGC_BIT_LOGIC_RST = 0;
  localparam int HGC_BIT_FULL_RST  = 1;
  localparam int HGC_BIT_RELOAD    = 2;
  localparam int HGC_BIT_RSVD_RW   = 5;
  localparam int HGC_BIT_PAR_EN    = 1;
  localparam int HGC_BIT_SLEEP_SEL = 2;
  localparam int HGC_BIT_OUT_EN    = 3;
  localparam int HGC_BIT_OUT_MODE  = 4;
  localparam int HGC_BIT_INIT_DONE = 6;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0]  HGC_CFG_RESET    = 8'h1E;
  localparam logic [7:0]  HGC_CFG_WMASK    = 8'h1E;
  localparam logic [7:0]  HGC_THR_HI_RESET = 8'h01;
  localparam logic [7:0]  HGC_THR_LO_RESET = 8'h00;
  localparam logic [6:0]  HGC_ADDR_RESET   = 7'h00;
  localparam logic [15:0] HGC_CNT_MAX      = 16'hFFFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    HGC_TX_HIZ    = 2'b00,
    HGC_TX_HS0    = 2'b01,
    HGC_TX_LP11   = 2'b10,
    HGC_TX_NORMAL = 2'b11
  } hgc_tx_state_e;

  typedef enum logic [0:0]
  {
    HGC_LOAD_IDLE = 1'b0,
    HGC_LOAD_BUSY = 1'b1
  } hgc_load_state_e;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hgc_reg_req_s;

  typedef struct packed
  {
    logic out_mode;
    logic out_en;
    logic sleep_sel;
    logic parity_en;
  } hgc_cfg_s;

endpackage

// ==== tb/hgc_fuse_model.sv ====
// Behavioural fuse loader that answers the control bank's load start pulses.
// Assumes one clock domain shared with the bank and an active-low async reset.
`timescale 1ns/1ps
module hgc_fuse_model
#(
  parameter int LOAD_CYCLES = 20
)
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic start_in,
  output logic      done_out
);
  // ----------------------------------------
  // Load timer
  // ----------------------------------------
  // A new start while busy restarts the count, as a real reload would.
  int count_reg;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= 0;
      done_out  <= 1'b0;
    end
    else
    begin
      done_out  <= (count_reg == 1);
      count_reg <= start_in ? LOAD_CYCLES : (count_reg > 0 ? count_reg - 1 : 0);
    end
  end
endmodule // hgc_fuse_model

// ==== tb/hgc_global_regs_tb.sv ====
// Self-checking bench for the hub global control bank.
// Assumes the bank and the fuse loader model share the bench clock.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module hgc_global_regs_tb;
  import hgc_pkg::*;
  typedef struct packed
  {
    logic [7:0]    cfg;
    logic [3:0]    lock;
    logic [3:0]    asg;
    logic          txen;
    hgc_tx_state_e exp;
  } hgc_row_s;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic          clk_in      = 1'b0;
  logic          reset_n_in  = 1'b0;
  hgc_reg_req_s  req         = '0;
  logic [6:0]    strap       = 7'h55;
  logic [3:0]    lock        = 4'h0;
  logic [3:0]    asg         = 4'hF;
  logic          txen        = 1'b1;
  logic [3:0]    par_err     = 4'h0;
  logic          fuse_done;
  logic [7:0]    rdata;
  logic [6:0]    bus_addr;
  logic          load_start;
  logic          soft_rst;
  logic          init_done;
  hgc_cfg_s      cfg;
  hgc_tx_state_e tx_state;
  logic [3:0]    par_flag;
  int            n_mismatch  = 0;
  int            check_count = 0;
  int            cycles      = 0;
  // Sleep, enable, mode and lock combinations with the output state each must give.
  hgc_row_s rows [8] = '{'{8'h05, 4'hF, 4'hF, 1'b1, HGC_TX_HIZ},  '{8'h08, 4'h0, 4'hF, 1'b1, HGC_TX_HIZ},
                         '{8'h18, 4'h0, 4'hF, 1'b1, HGC_TX_HS0},  '{8'h1C, 4'h0, 4'hF, 1'b1, HGC_TX_LP11},
                         '{8'h1C, 4'h1, 4'h2, 1'b1, HGC_TX_LP11}, '{8'h1C, 4'h3, 4'h2, 1'b1, HGC_TX_NORMAL},
                         '{8'h1D, 4'hF, 4'hF, 1'b0, HGC_TX_LP11}, '{8'h0C, 4'hF, 4'hF, 1'b1, HGC_TX_NORMAL}};

  hgc_global_regs #(.NUM_PORTS(4)) dut
  (
    .clk_in              (clk_in),
    .reset_n_in          (reset_n_in),
    .reg_req_in          (req),
    .strap_address_in    (strap),
    .rx_lock_in          (lock),
    .port_assign_in      (asg),
    .port_tx_enable_in   (txen),
    .fuse_load_done_in   (fuse_done),
    .parity_error_in     (par_err),
    .reg_rdata_out       (rdata),
    .bus_address_out     (bus_addr),
    .fuse_load_start_out (load_start),
    .logic_reset_out     (soft_rst),
    .init_done_out       (init_done),
    .cfg_out             (cfg),
    .tx_state_out        (tx_state),
    .parity_flag_out     (par_flag)
  );

  hgc_fuse_model #(.LOAD_CYCLES(20)) fuse
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .start_in   (load_start),
    .done_out   (fuse_done)
  );

  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Requests rise one nanosecond after an edge and stand for exactly one taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    #1 req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    #1 req = '0;
    `CHK(rdata, e)
  endtask

  task automatic pulse_par(input logic [3:0] p, input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      #1 par_err = p;
      @(posedge clk_in);
      #1 par_err = 4'h0;
    end
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic wait_init();
    for (int i = 0; i < 100 && init_done !== 1'b1; i++) @(posedge clk_in);
    #1;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("ERROR %0t run did not finish in time", $time);
      close_out();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    `CHK(init_done, 1'b0)
    wait_init();
    `CHK(init_done, 1'b1)
    rd(8'h00, 8'hAA);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h1E);
    rd(8'h04, 8'h40);
    rd(8'h05, 8'h01);
    rd(8'h06, 8'h00);
    rd(8'h03, 8'h00);
    `CHK(cfg, 4'hF)
    $display("test reset values done");
    foreach (rows[i])
    begin
      wr(8'h02, rows[i].cfg);
      lock = rows[i].lock;
      asg  = rows[i].asg;
      txen = rows[i].txen;
      repeat (2) @(posedge clk_in);
      #1 `CHK(tx_state, rows[i].exp)
      rd(8'h02, rows[i].cfg & 8'h1E);
    end
    $display("test output state table done");
    wr(8'h00, 8'h54);
    rd(8'h00, 8'hAA);
    wr(8'h00, 8'h55);
    `CHK(bus_addr, 7'h2A)
    rd(8'h00, 8'h55);
    wr(8'h00, 8'h54);
    `CHK(bus_addr, 7'h55)
    wr(8'h00, 8'h55);
    $display("test address override done");
    wr(8'h01, 8'h04);
    `CHK(load_start, 1'b1)
    `CHK(init_done, 1'b0)
    #20 rd(8'h01, 8'h00);
    wait_init();
    `CHK(init_done, 1'b1)
    $display("test reload done");
    wr(8'h02, 8'h1E);
    // Low byte first, so the threshold never passes through zero and sets every flag.
    wr(8'h06, 8'h03);
    wr(8'h05, 8'h00);
    pulse_par(4'h1, 2);
    `CHK(par_flag, 4'h0)
    pulse_par(4'h1, 1);
    `CHK(par_flag, 4'h1)
    wr(8'h02, 8'h1C);
    pulse_par(4'h2, 4);
    `CHK(par_flag, 4'h1)
    $display("test parity threshold done");
    wr(8'h01, 8'h01);
    `CHK(soft_rst, 1'b1)
    @(posedge clk_in);
    #1 `CHK(tx_state, HGC_TX_HIZ)
    `CHK(par_flag, 4'h0)
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h03);
    rd(8'h00, 8'h55);
    $display("test logic reset done");
    strap = 7'h33;
    wr(8'h01, 8'h02);
    `CHK(soft_rst, 1'b1)
    repeat (2) @(posedge clk_in);
    #1 rd(8'h00, 8'h66);
    rd(8'h06, 8'h00);
    rd(8'h02, 8'h1E);
    rd(8'h01, 8'h00);
    wait_init();
    `CHK(init_done, 1'b1)
    $display("test full reset done");
    close_out();
  end
endmodule // hgc_global_regs_tb
